// [verilog/nbw_map.vh]
`ifndef NBW_MAP_VH
`define NBW_MAP_VH

// Register byte offsets
`define NBW_OFS_WINDOW3_SETUP 12'h4A0
`define NBW_OFS_COMPANION 12'h4C0
`define NBW_OFS_BAR3 12'h4C4

// Setup register field positions
`define NBW_SIZE_LSB 4
`define NBW_SIZE_MSB 9
`define NBW_MODE_BIT 10
`define NBW_TRAN_LSB 11
`define NBW_TRAN_MSB 12
`define NBW_PART_LSB 13
`define NBW_PART_MSB 15
`define NBW_EN_BIT 31

// Read-only field values
`define NBW_MODE_WINDOW 1'h0
`define NBW_TRAN_DIRECT 2'h0

// Companion register fields and encodings
`define NBW_COMP_SPACE_BIT 0
`define NBW_COMP_TYPE_LSB 1
`define NBW_COMP_TYPE_MSB 2
`define NBW_SPACE_MEMORY 1'h0
`define NBW_TYPE_ADDR32 2'h0
`define NBW_TYPE_ADDR64 2'h2

// Base field placement and size limits
`define NBW_BASE_LSB 4
`define NBW_SIZE_MIN 6'h04
`define NBW_SIZE_MAX 6'h1F

// Reset values
`define NBW_RST_SIZE 6'h00
`define NBW_RST_PART 3'h0
`define NBW_RST_EN 1'h0
`define NBW_RST_BASE 28'h0000000
`define NBW_RST_UPPER 32'h00000000
`define NBW_RST_COMP 3'h0

`endif

// [verilog/nbw_base_mask.v]
`include "nbw_map.vh"

// ****************************************
// Writable-bit mask of the base field
// ****************************************
module nbw_base_mask (
  input wire [5:0] size,
  output wire [27:0] mask
);

  genvar gi;

  // Bit gi holds bus address bit gi+4; kept only at or above size
  generate
    for (gi = 0; gi < 28; gi = gi + 1) begin : g_bit
      // Bus address position of this base bit
      localparam [6:0] ADDR_POS = gi + `NBW_BASE_LSB;
      assign mask[gi] = (size >= `NBW_SIZE_MIN) &&
                        ({1'b0, size} <= ADDR_POS);
    end
  endgenerate

endmodule // nbw_base_mask

// [verilog/nbw_window3.v]
// Functional notes
// - A six-bit writable size field at bits 9:4 sets the aperture as two to that power.
// - Bit zero of the base field lines up with bus address bit four.
// - With a size of four or more, base bits at or above the size value are writable.
// - Base bits from address four up to below the size read zero and ignore writes.
// - A size below four makes every base bit read-only zero and disables the window.
// - A size above 31 also makes every base bit read-only zero and disables the window.
// - When the companion is 64-bit memory, this BAR holds its upper 32 base bits.
// - The mode bit 10 is read-only zero, address window operation.
// - The translation kind bits 12:11 are read-only zero, direct translation.
// - A writable three-bit target partition at bits 15:13 resets to zero.
// - The companion type encodes 32-bit as zero and 64-bit as two.
// - With enable bit 31 clear and no 64-bit memory companion, the BAR is disabled and reads zero.
`include "nbw_map.vh"

module nbw_window3 (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg win_active,
  output reg upper_mode,
  output reg [31:0] win_base,
  output reg [5:0] win_size,
  output reg [2:0] target_partition
);

  // ****************************************
  // Stored state
  // ****************************************
  reg [5:0] size_q;
  reg [2:0] part_q;
  reg en_q;
  reg [27:0] base_q;
  reg [31:0] upper_q;
  reg comp_space_q;
  reg [1:0] comp_type_q;

  wire [27:0] base_mask;
  wire upper_sel;
  wire window_on;
  wire [31:0] setup_rd;
  wire [31:0] bar_rd;
  wire [31:0] comp_rd;
  wire acc_setup;
  wire hit_setup;
  wire hit_bar;
  wire hit_comp;
  wire hit_any;
  wire wr_fire;
  wire [31:0] wmask;
  reg [31:0] rd_mux;
  wire wr_setup;
  wire wr_bar;
  wire wr_comp;
  wire lane0_we;
  wire lane1_we;
  wire lane3_we;
  wire [27:0] base_we;
  reg [5:0] size_d;
  reg [2:0] part_d;
  reg en_d;
  reg [27:0] base_d;
  reg [31:0] upper_d;
  reg comp_space_d;
  reg [1:0] comp_type_d;
  reg pready_d;
  reg pslverr_d;
  reg [31:0] prdata_d;
  reg win_active_d;
  reg upper_mode_d;
  reg [31:0] win_base_d;
  reg [5:0] win_size_d;
  reg [2:0] target_partition_d;

  // ****************************************
  // Base mask from current size
  // ****************************************
  nbw_base_mask u_mask (
    .size(size_q),
    .mask(base_mask)
  );

  // Companion is 64-bit memory space
  assign upper_sel = (comp_space_q == `NBW_SPACE_MEMORY) &&
                     (comp_type_q == `NBW_TYPE_ADDR64);

  // Window decodes only with enable, a legal size and no 64-bit memory companion
  assign window_on = en_q && !upper_sel && (size_q >= `NBW_SIZE_MIN) &&
                     (size_q <= `NBW_SIZE_MAX);

  // Setup read image with fixed mode and translation kind
  assign setup_rd = {en_q, 15'h0000, part_q, `NBW_TRAN_DIRECT, `NBW_MODE_WINDOW,
                     size_q, 4'h0};

  // BAR read image, masked continuously
  assign bar_rd = upper_sel ? upper_q :
                  (en_q ? {base_q & base_mask, 4'h0} : 32'h00000000);

  assign comp_rd = {29'h00000000, comp_type_q, comp_space_q};

  // ****************************************
  // APB decode
  // ****************************************
  assign acc_setup = psel && !penable;
  assign hit_setup = (paddr == `NBW_OFS_WINDOW3_SETUP);
  assign hit_bar = (paddr == `NBW_OFS_BAR3);
  assign hit_comp = (paddr == `NBW_OFS_COMPANION);
  assign hit_any = hit_setup || hit_bar || hit_comp;
  assign wr_fire = psel && penable && pready && pwrite && hit_any;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Read data selection
  always @* begin
    rd_mux = 32'h00000000;
    if (hit_setup) begin
      rd_mux = setup_rd;
    end else if (hit_bar) begin
      rd_mux = bar_rd;
    end else if (hit_comp) begin
      rd_mux = comp_rd;
    end
  end

  // ****************************************
  // Bus answer, one access cycle
  // ****************************************
  // Answer for the access cycle that follows a setup cycle
  always @* begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata;
    if (acc_setup) begin
      pready_d = 1'b1;
      pslverr_d = !hit_any;
      prdata_d = (pwrite || !hit_any) ? 32'h00000000 : rd_mux;
    end
  end

  // Answer flip-flops, zero wait states
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= pready_d;
      pslverr <= pslverr_d;
      prdata <= prdata_d;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Register selects for a completed write
  assign wr_setup = wr_fire && hit_setup;
  assign wr_bar = wr_fire && hit_bar;
  assign wr_comp = wr_fire && hit_comp;

  // Setup byte lanes that carry fields
  assign lane0_we = wr_setup && pstrb[0];
  assign lane1_we = wr_setup && pstrb[1];
  assign lane3_we = wr_setup && pstrb[3];

  // Base bits that are writable and strobed
  assign base_we = base_mask & wmask[31:4];

  // Size field, still writable in upper mode
  always @* begin
    size_d = size_q;
    if (lane0_we) begin
      size_d[3:0] = pwdata[7:4];
    end
    if (lane1_we) begin
      size_d[5:4] = pwdata[9:8];
    end
  end

  // Target partition
  always @* begin
    part_d = part_q;
    if (lane1_we) begin
      part_d = pwdata[`NBW_PART_MSB:`NBW_PART_LSB];
    end
  end

  // Enable bit
  always @* begin
    en_d = en_q;
    if (lane3_we) begin
      en_d = pwdata[`NBW_EN_BIT];
    end
  end

  // Base bits below size keep their stored value
  always @* begin
    base_d = base_q;
    if (wr_bar && !upper_sel) begin
      base_d = (base_q & ~base_we) | (pwdata[31:4] & base_we);
    end
  end

  // Upper base bits of the companion, all lanes
  always @* begin
    upper_d = upper_q;
    if (wr_bar && upper_sel) begin
      upper_d = (upper_q & ~wmask) | (pwdata & wmask);
    end
  end

  // Companion space indicator and type
  always @* begin
    comp_space_d = comp_space_q;
    comp_type_d = comp_type_q;
    if (wr_comp && pstrb[0]) begin
      comp_space_d = pwdata[`NBW_COMP_SPACE_BIT];
      comp_type_d = pwdata[`NBW_COMP_TYPE_MSB:`NBW_COMP_TYPE_LSB];
    end
  end

  // ****************************************
  // Field flip-flops
  // ****************************************
  // Size field
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      size_q <= `NBW_RST_SIZE;
    end else begin
      size_q <= size_d;
    end
  end

  // Target partition
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      part_q <= `NBW_RST_PART;
    end else begin
      part_q <= part_d;
    end
  end

  // Enable bit
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= `NBW_RST_EN;
    end else begin
      en_q <= en_d;
    end
  end

  // Base field
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_q <= `NBW_RST_BASE;
    end else begin
      base_q <= base_d;
    end
  end

  // Upper base bits
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_q <= `NBW_RST_UPPER;
    end else begin
      upper_q <= upper_d;
    end
  end

  // Companion configuration
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {comp_type_q, comp_space_q} <= `NBW_RST_COMP;
    end else begin
      comp_space_q <= comp_space_d;
      comp_type_q <= comp_type_d;
    end
  end

  // ****************************************
  // Registered window status
  // ****************************************
  // Next status values from the current fields
  always @* begin
    win_active_d = window_on;
    upper_mode_d = upper_sel;
    win_base_d = window_on ? {base_q & base_mask, 4'h0} : bar_rd;
    win_size_d = size_q;
    target_partition_d = part_q;
  end

  // Window decode enable
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      win_active <= 1'b0;
    end else begin
      win_active <= win_active_d;
    end
  end

  // Upper extension flag
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_mode <= 1'b0;
    end else begin
      upper_mode <= upper_mode_d;
    end
  end

  // Effective base or upper bits
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      win_base <= 32'h00000000;
    end else begin
      win_base <= win_base_d;
    end
  end

  // Size copy
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      win_size <= 6'h00;
    end else begin
      win_size <= win_size_d;
    end
  end

  // Partition copy
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      target_partition <= 3'h0;
    end else begin
      target_partition <= target_partition_d;
    end
  end

endmodule // nbw_window3

// [tb/nbw_host.sv]
// ****
// Host issuing register accesses
// ****
module nbw_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // One transfer, held until pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // nbw_host

// [tb/nbw_window3_props.sv]
module nbw_window3_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic win_active,
  input wire logic upper_mode,
  input wire logic [31:0] win_base,
  input wire logic [5:0] win_size,
  input wire logic [2:0] target_partition
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Completed setup register writes and reads
  sequence wr_set_s;
    psel && !penable && pwrite && paddr == 12'h4A0 ##1 pready;
  endsequence
  sequence rd_set_s;
    psel && !penable && !pwrite && paddr == 12'h4A0 ##1 pready;
  endsequence
  size_copy_a: assert property (wr_set_s |-> ##2 win_size[3:0] == $past(pwdata[7:4], 2))
    else $error("size copy");
  part_copy_a: assert property (wr_set_s |-> ##2 target_partition == $past(pwdata[15:13], 2))
    else $error("partition copy");
  mode_zero_a: assert property (rd_set_s |-> !prdata[10])
    else $error("mode bit");
  tran_zero_a: assert property (rd_set_s |-> prdata[12:11] == 2'h0)
    else $error("translation kind");
  low_zero_a: assert property (win_active |-> (win_base & ~(32'hFFFFFFFF << win_size)) == 0)
    else $error("low base bits");
  size_off_a: assert property (win_size < 6'h04 |-> !win_active)
    else $error("small size active");
  upper_off_a: assert property (upper_mode |-> !win_active)
    else $error("upper mode active");
  off_zero_a: assert property (!win_active && !upper_mode |-> win_base == 32'h0)
    else $error("disabled base");
  bar_low_a: assert property (!psel ##1 psel && paddr == 12'h4C4 && !pwrite && !upper_mode
    ##1 pready |-> prdata[3:0] == 4'h0)
    else $error("bar low bits");
endmodule // nbw_window3_props
bind nbw_window3 nbw_window3_props u_props (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .win_active, .upper_mode, .win_base, .win_size, .target_partition);

// [tb/nbw_window3_tb_top.sv]
module nbw_window3_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [5:0] sz [6] = '{6'h04, 6'h14, 6'h1F, 6'h03, 6'h07, 6'h28};
  int bad_count, tests_run, cyc;
  nbw_window3 dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .win_active(), .upper_mode(), .win_base(), .win_size(),
    .target_partition());
  nbw_host host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr);
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk(n, e, rd);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask
  // Fixed and writable setup fields
  task t_fields;
    rdc("setup reset", 12'h4A0, 32'h0);
    wr(12'h4A0, 32'hFFFF_FFFF);
    rdc("setup bits", 12'h4A0, 32'h8000_E3F0);
  endtask
  // Base masking follows each size
  task t_mask;
    wr(12'h4A0, 32'h8000_0040);
    wr(12'h4C4, 32'hFFFF_FFFF);
    foreach (sz[i]) begin
      wr(12'h4A0, {22'h200000, sz[i], 4'h0});
      rdc("bar mask", 12'h4C4, (sz[i] < 6'h04) ? 32'h0 : 32'hFFFF_FFFF << sz[i]);
    end
    wr(12'h4A0, 32'h8000_0140);
    wr(12'h4C4, 32'h0000_0000);
    wr(12'h4A0, 32'h8000_0040);
    rdc("bar kept", 12'h4C4, 32'h000F_FFF0);
  endtask
  // Disable, upper half and unmapped access
  task t_modes;
    wr(12'h4A0, 32'h0000_0070);
    rdc("bar off", 12'h4C4, 32'h0);
    wr(12'h4C0, 32'h4);
    wr(12'h4C4, 32'h1234_5678);
    rdc("bar upper", 12'h4C4, 32'h1234_5678);
    wr(12'h4C0, 32'h2);
    rdc("bar type1", 12'h4C4, 32'h0);
    rdc("unmapped", 12'h100, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask
  // Reset in mid-run clears every field
  task t_reset;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdc("setup cleared", 12'h4A0, 32'h0);
    rdc("comp cleared", 12'h4C0, 32'h0);
    rdc("bar cleared", 12'h4C4, 32'h0);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    bad_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_fields();
    t_mask();
    t_modes();
    t_reset();
    complete_run();
  end
endmodule // nbw_window3_tb_top
